// ==== verilog/tvc_defs.svh ====
// Register offsets, field positions, reset values and timing counts of the vendor control bank
// What this block does
// [R1] Bit 5 of the second system control register turns bus voltage sensing on when set, reset 0.
// [R2] Bit 4 of the second system control register turns cable power sensing on when set, reset 0.
// [R3] With the continuous carrier select bit set, a carrier mode 2 test runs until it is withdrawn.
// [R4] With that bit clear, the carrier mode 2 test ends by itself 45 ms after it was requested.
// [R5] The charger detect reset bit is write-only and clears itself after a one is written.
// [R6] Writing one there returns the charger detect logic to idle; writing zero changes nothing.
// [R7] Bit 0 starts role swap signalling when one and stops it when zero, and the block follows it.
// [R8] Bit 7 of the debug function register disables channel two sensing when one, reset 1.
// [R9] Bit 6 of the debug function register disables channel one sensing when one, reset 1.
// [R10] Bits 7:4 of the first mode status register report the charger detect state, read-only.
// [R11] The cable power switch turns off above 160 C and stays off until back down to 130 C.
// [R12] Bit 6 of the second mode status register reads one while the cable power switch is hot and cable power is applied.
// [R13] Bit 7 of the external gate control register disables flat battery support, reset 0.
// [R14] Bit 1 of the external gate control register drives the sink power-path gate.
// [R15] Bit 0 of the external gate control register drives the source power-path gate.
// [R16] An over-temperature event of the cable power switch raises the vendor event bit 2 pulse.
// [R17] Writes to read-only bits are ignored and reserved read-only bits read as zero.
`ifndef TVC_DEFS_SVH
`define TVC_DEFS_SVH

`define TVC_ADDR_SYS_CTRL2      8'h81
`define TVC_ADDR_DEBUG_FUNC     8'h82
`define TVC_ADDR_MODE_STAT1     8'h83
`define TVC_ADDR_MODE_STAT2     8'h84
`define TVC_ADDR_EXT_GATE       8'h85

`define TVC_BIT_BUS_SENSE       5
`define TVC_BIT_CABLE_SENSE     4
`define TVC_BIT_CARRIER_CONT    2
`define TVC_BIT_CHG_RESET       1
`define TVC_BIT_SWAP_START      0
`define TVC_BIT_CH2_DIS         7
`define TVC_BIT_CH1_DIS         6
`define TVC_BIT_OVERTEMP        6
`define TVC_BIT_FLAT_BAT_DIS    7
`define TVC_BIT_SINK_GATE       1
`define TVC_BIT_SOURCE_GATE     0

`define TVC_RST_SYS_CTRL2       8'h00
`define TVC_RST_DEBUG_FUNC      8'hc0
`define TVC_RST_EXT_GATE        8'h00
`define TVC_SYS_CTRL2_RW_MASK   8'hfd
`define TVC_EXT_GATE_RW_MASK    8'h83

`define TVC_OT_TRIP_DEGC        160
`define TVC_OT_CLEAR_DEGC       130

`define TVC_CLK_MHZ             125
`define TVC_CARRIER_MS          45
`define TVC_CARRIER_CYCLES      (`TVC_CARRIER_MS * 1000 * `TVC_CLK_MHZ)

`endif

// ==== verilog/tvc_pkg.sv ====
// Types shared by the vendor control bank
package tvc_pkg;

    typedef enum logic [3:0] {
        CHG_IDLE      = 4'b0000,
        CHG_DIVIDER   = 4'b0011,
        CHG_DEDICATED = 4'b0101,
        CHG_TRYING    = 4'b0111,
        CHG_DELAY40   = 4'b1000,
        CHG_FIX5V     = 4'b1001,
        CHG_FIX9V     = 4'b1010,
        CHG_FIX12V    = 4'b1011,
        CHG_FIX20V    = 4'b1100,
        CHG_UNDEF     = 4'b1110,
        CHG_ALT       = 4'b1111
    } tvc_chg_state_type;

    typedef enum logic [1:0] {
        CAR_IDLE = 2'b00,
        CAR_RUN  = 2'b01,
        CAR_DONE = 2'b10
    } tvc_carrier_state_type;

    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tvc_reg_req_type;

    typedef struct packed {
        logic busSenseEn;
        logic cableSenseEn;
        logic ch1SenseDis;
        logic ch2SenseDis;
    } tvc_afe_ctrl_type;

    typedef struct packed {
        logic sinkGateOn;
        logic sourceGateOn;
        logic flatBatteryDis;
    } tvc_gate_ctrl_type;

endpackage : tvc_pkg

// ==== verilog/tvc_vendor_regs.sv ====
// Vendor control and status register bank of the port controller
`timescale 1ns/1ns
`include "tvc_defs.svh"

module tvc_vendor_regs
    import tvc_pkg::*;
#(
    parameter int unsigned CARRIER_CYCLES = `TVC_CARRIER_CYCLES
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // Register port from the port manager side
    input  wire tvc_reg_req_type   regReq,
    output logic [7:0]             rdata,
    // Analog front end controls
    output tvc_afe_ctrl_type       afeCtrl,
    // Power-path gate controls
    output tvc_gate_ctrl_type      gateCtrl,
    // Test carrier
    input  wire logic              carrierRequest,
    output logic                   carrierActive,
    // Role swap transmit
    output logic                   roleSwapTx,
    // Charger detection
    input  wire tvc_chg_state_type chgStateIn,
    output logic                   chgResetPulse,
    // Cable power switch temperature
    input  wire logic              tempAboveTrip,
    input  wire logic              tempAboveClear,
    input  wire logic              cablePowerApplied,
    output logic                   cablePowerSwitchOff,
    output logic                   overtempEvent
);

    localparam logic [31:0] CAR_LAST = 32'(CARRIER_CYCLES - 1);

    logic [7:0]            sysCtrl2_q;
    logic [7:0]            debugFunc_q;
    logic [7:0]            extGate_q;
    logic                  chgReset_q;
    tvc_chg_state_type     chgState_q;
    logic                  overtemp_q;
    tvc_carrier_state_type carState_q;
    logic [31:0]           carCount_q;
    logic                  wrSys;
    logic                  wrDbg;
    logic                  wrGate;

    assign wrSys  = regReq.wrEn && (regReq.addr == `TVC_ADDR_SYS_CTRL2);
    assign wrDbg  = regReq.wrEn && (regReq.addr == `TVC_ADDR_DEBUG_FUNC);
    assign wrGate = regReq.wrEn && (regReq.addr == `TVC_ADDR_EXT_GATE);

    // Writable control bits; the self-clearing reset bit never stores
    always_ff @(posedge clk) begin
        if (srst) begin
            sysCtrl2_q <= `TVC_RST_SYS_CTRL2;
        end else if (wrSys) begin
            sysCtrl2_q <= regReq.wdata & `TVC_SYS_CTRL2_RW_MASK; // R1 R2 R7
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            debugFunc_q <= `TVC_RST_DEBUG_FUNC; // R8
        end else if (wrDbg) begin
            debugFunc_q <= regReq.wdata; // R9
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            extGate_q <= `TVC_RST_EXT_GATE;
        end else if (wrGate) begin
            extGate_q <= regReq.wdata & `TVC_EXT_GATE_RW_MASK; // R17
        end
    end

    // One-cycle charger detect reset; zero writes do nothing
    always_ff @(posedge clk) begin
        if (srst) begin
            chgReset_q <= 1'b0;
        end else begin
            chgReset_q <= wrSys && regReq.wdata[`TVC_BIT_CHG_RESET]; // R5 R6
        end
    end

    // Reported state is forced to idle while the reset takes effect
    always_ff @(posedge clk) begin
        if (srst) begin
            chgState_q <= CHG_IDLE;
        end else if (chgReset_q) begin
            chgState_q <= CHG_IDLE; // R6
        end else begin
            chgState_q <= chgStateIn; // R10
        end
    end

    // Hysteresis: trip above high point, release only below low point
    always_ff @(posedge clk) begin
        if (srst) begin
            overtemp_q <= 1'b0;
        end else if (tempAboveTrip) begin
            overtemp_q <= 1'b1; // R11
        end else if (!tempAboveClear) begin
            overtemp_q <= 1'b0; // R11
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            overtempEvent <= 1'b0;
        end else begin
            overtempEvent <= tempAboveTrip && !overtemp_q; // R16
        end
    end

    // Carrier test: timed unless continuous select is set; restart needs a new request
    always_ff @(posedge clk) begin
        if (srst) begin
            carState_q <= CAR_IDLE;
            carCount_q <= 32'h0;
        end else begin
            case (carState_q)
                CAR_IDLE: begin
                    carCount_q <= 32'h0;
                    if (carrierRequest) begin
                        carState_q <= CAR_RUN;
                    end
                end
                CAR_RUN: begin
                    if (!carrierRequest) begin
                        carState_q <= CAR_IDLE;
                    end else if (sysCtrl2_q[`TVC_BIT_CARRIER_CONT]) begin
                        carCount_q <= 32'h0; // R3
                    end else if (carCount_q >= CAR_LAST) begin
                        carState_q <= CAR_DONE; // R4
                    end else begin
                        carCount_q <= carCount_q + 32'h1;
                    end
                end
                CAR_DONE: begin
                    if (!carrierRequest) begin
                        carState_q <= CAR_IDLE;
                    end
                end
                default: begin
                    carState_q <= CAR_IDLE;
                end
            endcase
        end
    end

    // Read mux; reserved read-only bits and unmapped addresses give zero
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else if (regReq.rdEn) begin
            case (regReq.addr)
                `TVC_ADDR_SYS_CTRL2:  rdata <= sysCtrl2_q;
                `TVC_ADDR_DEBUG_FUNC: rdata <= debugFunc_q;
                `TVC_ADDR_MODE_STAT1: rdata <= {chgState_q, 4'h0}; // R10 R17
                `TVC_ADDR_MODE_STAT2: rdata <= {1'b0, overtemp_q && cablePowerApplied, 6'h00}; // R12
                `TVC_ADDR_EXT_GATE:   rdata <= extGate_q;
                default:              rdata <= 8'h00;
            endcase
        end
    end

    assign afeCtrl.busSenseEn    = sysCtrl2_q[`TVC_BIT_BUS_SENSE]; // R1
    assign afeCtrl.cableSenseEn  = sysCtrl2_q[`TVC_BIT_CABLE_SENSE]; // R2
    assign afeCtrl.ch2SenseDis   = debugFunc_q[`TVC_BIT_CH2_DIS]; // R8
    assign afeCtrl.ch1SenseDis   = debugFunc_q[`TVC_BIT_CH1_DIS]; // R9
    assign gateCtrl.flatBatteryDis = extGate_q[`TVC_BIT_FLAT_BAT_DIS]; // R13
    assign gateCtrl.sinkGateOn   = extGate_q[`TVC_BIT_SINK_GATE]; // R14
    assign gateCtrl.sourceGateOn = extGate_q[`TVC_BIT_SOURCE_GATE]; // R15
    assign roleSwapTx            = sysCtrl2_q[`TVC_BIT_SWAP_START]; // R7
    assign chgResetPulse         = chgReset_q; // R6
    assign carrierActive         = (carState_q == CAR_RUN); // R3 R4
    assign cablePowerSwitchOff   = overtemp_q; // R11

endmodule : tvc_vendor_regs

// ==== sim/tvc_vendor_regs_chk.sv ====
// Port checker for the vendor control bank
`timescale 1ns/1ns
module tvc_vendor_regs_chk
    import tvc_pkg::*;
#(
    parameter int unsigned CARRIER_CYCLES = 50
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              srst,
    // Register port
    input wire tvc_reg_req_type   regReq,
    input wire logic [7:0]        rdata,
    // Controls and status
    input wire tvc_afe_ctrl_type  afeCtrl,
    input wire tvc_gate_ctrl_type gateCtrl,
    input wire logic              carrierRequest,
    input wire logic              carrierActive,
    input wire logic              roleSwapTx,
    input wire logic              chgResetPulse,
    input wire logic              tempAboveTrip,
    input wire logic              tempAboveClear,
    input wire logic              cablePowerApplied,
    input wire logic              cablePowerSwitchOff,
    input wire logic              overtempEvent
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic        wr81, wr82, wr85, contQ;
    logic [31:0] runQ;
    assign wr81 = regReq.wrEn && regReq.addr == 8'h81;
    assign wr82 = regReq.wrEn && regReq.addr == 8'h82;
    assign wr85 = regReq.wrEn && regReq.addr == 8'h85;
    // Shadow of the continuous carrier select, so the run length is judged by the right mode
    always_ff @(posedge clk) begin
        if (srst) contQ <= 1'b0;
        else if (wr81) contQ <= regReq.wdata[2];
    end
    always_ff @(posedge clk) begin
        if (srst || !carrierActive) runQ <= '0;
        else runQ <= runQ + 1;
    end
    AST_SENSE: assert property (wr81 |=> afeCtrl.busSenseEn == $past(regReq.wdata[5])
        && afeCtrl.cableSenseEn == $past(regReq.wdata[4])) else $error("sense enable wrong");
    AST_CH_DIS: assert property (wr82 |=> {afeCtrl.ch2SenseDis, afeCtrl.ch1SenseDis}
        == $past(regReq.wdata[7:6])) else $error("channel disable wrong");
    AST_CHG_RST: assert property (wr81 |=> chgResetPulse == $past(regReq.wdata[1]))
        else $error("charger reset pulse wrong");
    AST_SWAP: assert property (wr81 |=> roleSwapTx == $past(regReq.wdata[0]))
        else $error("role swap level wrong");
    AST_GATES: assert property (wr85 |=> gateCtrl == $past({regReq.wdata[1:0],
        regReq.wdata[7]})) else $error("gate controls wrong");
    AST_OT_TRIP: assert property (tempAboveTrip && !cablePowerSwitchOff
        |=> cablePowerSwitchOff && overtempEvent) else $error("overtemp trip missed");
    AST_OT_HOLD: assert property (cablePowerSwitchOff && tempAboveClear |=> cablePowerSwitchOff)
        else $error("switch released while hot");
    AST_CAR_CONT: assert property (contQ && carrierActive && carrierRequest |=> carrierActive)
        else $error("continuous carrier ended");
    AST_CAR_END: assert property (!contQ && carrierActive |-> runQ <= CARRIER_CYCLES)
        else $error("carrier ran too long");
    AST_RD84: assert property (regReq.rdEn && regReq.addr == 8'h84 |=> rdata ==
        {1'b0, $past(cablePowerSwitchOff && cablePowerApplied), 6'h00}) else $error("0x84 wrong");
    COV_CAR: cover property ($fell(carrierActive) && carrierRequest);
    COV_OT: cover property (overtempEvent);
    COV_CHG: cover property (chgResetPulse);
endmodule : tvc_vendor_regs_chk

// ==== sim/tvc_port_mgr.sv ====
// Port manager model issuing single-byte register accesses
`timescale 1ns/1ns
module tvc_port_mgr
    import tvc_pkg::*;
(
    // Clock and register port
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output tvc_reg_req_type regReq
);
    initial regReq = '0;
    // Released address and data show the inverse, so a stale value is never mistaken for live
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clk);
        regReq <= '{w, !w, a, d};
        @(posedge clk);
        regReq <= '{1'b0, 1'b0, ~a, ~d};
        @(posedge clk);
        q = rdata;
    endtask : acc
endmodule : tvc_port_mgr

// ==== sim/tvc_vendor_regs_tb.sv ====
// Self-checking bench for the vendor control bank
`timescale 1ns/1ns
module tvc_vendor_regs_tb;
    import tvc_pkg::*;
    logic              clk, srst, carrierRequest, tempAboveTrip, tempAboveClear, cablePowerApplied;
    logic              carrierActive, roleSwapTx, chgResetPulse, cablePowerSwitchOff, overtempEvent;
    logic [7:0]        rdata, q;
    tvc_reg_req_type   regReq;
    tvc_afe_ctrl_type  afeCtrl;
    tvc_gate_ctrl_type gateCtrl;
    tvc_chg_state_type chgStateIn;
    int                mismatches = 0;
    int                checks = 0;
    typedef struct packed {logic [7:0] a, d, r; logic [3:0] afe; logic [2:0] gate;} tvc_row_type;
    tvc_row_type rows [9] = '{{8'h81, 8'h35, 8'h35, 4'hf, 3'h0}, {8'h82, 8'h40, 8'h40, 4'he, 3'h0},
        {8'h85, 8'hff, 8'h83, 4'he, 3'h7}, {8'h81, 8'h22, 8'h20, 4'ha, 3'h7},
        {8'h85, 8'h02, 8'h02, 4'ha, 3'h4}, {8'h83, 8'hff, 8'ha0, 4'ha, 3'h4},
        {8'h86, 8'h5a, 8'h00, 4'ha, 3'h4}, {8'h82, 8'h80, 8'h80, 4'h9, 3'h4},
        {8'h84, 8'hff, 8'h00, 4'h9, 3'h4}};
    tvc_port_mgr u_mgr (.clk(clk), .rdata(rdata), .regReq(regReq));
    tvc_vendor_regs #(.CARRIER_CYCLES(50)) u_dut (.clk(clk), .srst(srst), .regReq(regReq),
        .rdata(rdata), .afeCtrl(afeCtrl), .gateCtrl(gateCtrl), .carrierRequest(carrierRequest),
        .carrierActive(carrierActive), .roleSwapTx(roleSwapTx), .chgStateIn(chgStateIn),
        .chgResetPulse(chgResetPulse), .tempAboveTrip(tempAboveTrip),
        .tempAboveClear(tempAboveClear), .cablePowerApplied(cablePowerApplied),
        .cablePowerSwitchOff(cablePowerSwitchOff), .overtempEvent(overtempEvent));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Generous bound: the whole sequence needs well under a thousand cycles
    initial begin
        #100000;
        mismatches++;
        test_done();
    end
    initial begin
        {srst, carrierRequest, tempAboveTrip, tempAboveClear, cablePowerApplied} = 5'b10001;
        chgStateIn = CHG_FIX9V;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            u_mgr.acc(1'b1, rows[i].a, rows[i].d, q);
            chk({7'h00, chgResetPulse}, {7'h00, rows[i].a == 8'h81 && rows[i].d[1]});
            u_mgr.acc(1'b0, rows[i].a, 8'h00, q);
            chk(q, rows[i].r);
            chk({4'h0, afeCtrl}, {4'h0, rows[i].afe});
            chk({5'h00, gateCtrl}, {5'h00, rows[i].gate});
            if (rows[i].a == 8'h81) chk({7'h00, roleSwapTx}, {7'h00, rows[i].d[0]});
        end
        @(posedge clk) carrierRequest <= 1'b1;
        repeat (2) @(posedge clk);
        chk({7'h00, carrierActive}, 8'h01);
        repeat (48) @(posedge clk);
        chk({7'h00, carrierActive}, 8'h01);
        repeat (12) @(posedge clk);
        chk({7'h00, carrierActive}, 8'h00);
        carrierRequest <= 1'b0;
        u_mgr.acc(1'b1, 8'h81, 8'h04, q);
        carrierRequest <= 1'b1;
        repeat (80) @(posedge clk);
        chk({7'h00, carrierActive}, 8'h01);
        {tempAboveTrip, tempAboveClear} <= 2'b11;
        repeat (2) @(posedge clk);
        chk({6'h00, cablePowerSwitchOff, overtempEvent}, 8'h03);
        {carrierRequest, tempAboveTrip} <= 2'b00;
        u_mgr.acc(1'b0, 8'h84, 8'h00, q);
        chk(q, 8'h40);
        tempAboveClear <= 1'b0;
        repeat (2) @(posedge clk);
        chk({6'h00, cablePowerSwitchOff, overtempEvent}, 8'h00);
        u_mgr.acc(1'b0, 8'h84, 8'h00, q);
        chk(q, 8'h00);
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        u_mgr.acc(1'b0, 8'h81, 8'h00, q);
        chk(q, 8'h00);
        u_mgr.acc(1'b0, 8'h82, 8'h00, q);
        chk(q, 8'hc0);
        u_mgr.acc(1'b0, 8'h85, 8'h00, q);
        chk(q, 8'h00);
        chk({4'h0, afeCtrl}, 8'h03);
        chk({5'h00, gateCtrl}, 8'h00);
        chk({7'h00, roleSwapTx}, 8'h00);
        test_done();
    end
endmodule : tvc_vendor_regs_tb
bind tvc_vendor_regs tvc_vendor_regs_chk #(.CARRIER_CYCLES(CARRIER_CYCLES)) u_chk (
    .clk(clk), .srst(srst), .regReq(regReq), .rdata(rdata), .afeCtrl(afeCtrl),
    .gateCtrl(gateCtrl), .carrierRequest(carrierRequest), .carrierActive(carrierActive),
    .roleSwapTx(roleSwapTx), .chgResetPulse(chgResetPulse), .tempAboveTrip(tempAboveTrip),
    .tempAboveClear(tempAboveClear), .cablePowerApplied(cablePowerApplied),
    .cablePowerSwitchOff(cablePowerSwitchOff), .overtempEvent(overtempEvent));
